// ### pkg/tccs_map.svh
// Offsets, field positions, reset values and limits of the count clock control block.
// Assumes inclusion by the design and bench files by bare name.
`ifndef TCCS_MAP_SVH
`define TCCS_MAP_SVH
// Register indices; the byte address is four times the index, decoded in a 12-bit window
`define TCCS_IDX_CTRL_CH0 16'h5068
`define TCCS_IDX_CTRL_CH1 16'h5069
`define TCCS_OFS_CTRL_CH0 12'h1A0
`define TCCS_OFS_CTRL_CH1 12'h1A4
`define TCCS_CTRL_RESET 8'h00
`define TCCS_DIV_MSB 7
`define TCCS_DIV_LSB 4
`define TCCS_SRC_MSB 3
`define TCCS_SRC_LSB 2
`define TCCS_SHARED_BIT 1
`define TCCS_GATE_BIT 0
`define TCCS_DIV_MAX_INT 4'hE
`define TCCS_DIV_MAX_SLOW 4'h8
`define TCCS_PRESCALE_W 14
`define TCCS_RESP_OKAY 2'h0
`define TCCS_RESP_SLVERR 2'h2
`endif

// ### pkg/tccs_pkg.sv
// Types shared by the count clock control block.
// Assumes tccs_map.svh holds the numeric constants.
package tccs_pkg;
	typedef enum logic [1:0] {
		TCCS_SRC_INT_RC = 2'h0,
		TCCS_SRC_SLOW_XTAL = 2'h1,
		TCCS_SRC_FAST_XTAL = 2'h2,
		TCCS_SRC_EXT_PIN = 2'h3
	} tccs_src_t;

	typedef struct packed {
		logic [3:0] prescale_select;
		tccs_src_t source_select;
		logic shared_clock_mode;
		logic count_clock_gate;
	} tccs_ctrl_t;

	typedef struct packed {
		logic [11:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [11:0] araddr;
		logic arvalid;
		logic rready;
	} tccs_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} tccs_axi_rsp_t;

	typedef enum logic [2:0] {
		TCCS_WR_IDLE = 3'h1,
		TCCS_WR_COLLECT = 3'h2,
		TCCS_WR_RESP = 3'h4
	} tccs_wr_state_t;
endpackage

// ### design/tccs_chan.sv
// One channel's count enable generator: source select, prescaler and gate.
// Assumes oscillator ticks are single-cycle pulses on clock_i and ext pin already synchronised.
`include "tccs_map.svh"
module tccs_chan (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire tccs_pkg::tccs_ctrl_t ctrl_i,
	input wire logic [3:0] tick_i,
	output logic count_en_o
);
	typedef struct packed {
		logic [`TCCS_PRESCALE_W-1:0] div;
		logic en;
	} tccs_chan_st_t;

	tccs_chan_st_t q, d;
	logic src_tick;
	logic div_hit;
	logic [`TCCS_PRESCALE_W-1:0] mask;

	always_comb begin
		src_tick = tick_i[ctrl_i.source_select];
		mask = (`TCCS_PRESCALE_W'(1) << ctrl_i.prescale_select) - `TCCS_PRESCALE_W'(1);
		div_hit = ((q.div & mask) == mask);
		d = q;
		d.en = 1'b0;
		if (!ctrl_i.count_clock_gate) begin
			d.div = '0;
		end else if (src_tick) begin
			if (ctrl_i.source_select == tccs_pkg::TCCS_SRC_EXT_PIN) begin
				d.en = 1'b1;
			end else if (ctrl_i.prescale_select != 4'hF) begin
				d.div = q.div + `TCCS_PRESCALE_W'(1);
				d.en = div_hit;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign count_en_o = q.en;
endmodule // tccs_chan

// ### design/tccs_top.sv
// Count clock control for a two-channel timer, with AXI4-Lite register access.
// Assumes oscillator ticks are single-cycle pulses in the clock_i domain; ext pins are asynchronous.
// Overview of operation
// - Internal sources divide by two to the prescale code; 0xF reserved, reset zero.
// - Slow crystal allows prescale codes up to 1/256 only.
// - Two-bit source field picks RC, slow crystal, fast crystal or pin.
// - Shared mode on channel 0 sends channel 0's clock to both channels.
// - With shared mode off, each channel uses its own settings.
// - Shared mode bit only in channel 0; channel 1 bit reads zero.
// - Count clock reaches a counter only while the supplying channel's gate bit is set (channel 0's in shared mode).
// - Gate bit resets to zero.
//
// Added by the designer: the AXI4-Lite register port.
`include "tccs_map.svh"
module tccs_top (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire tccs_pkg::tccs_axi_req_t axi_req_i,
	output tccs_pkg::tccs_axi_rsp_t axi_rsp_o,
	input wire logic int_rc_tick_i,
	input wire logic slow_xtal_tick_i,
	input wire logic fast_xtal_tick_i,
	input wire logic [1:0] ext_count_clock_pin_i,
	output logic [1:0] count_en_o
);
	typedef struct packed {
		tccs_pkg::tccs_ctrl_t [1:0] ctrl;
		logic [1:0] ext_s1;
		logic [1:0] ext_s2;
		logic [1:0] ext_s3;
		tccs_pkg::tccs_wr_state_t wr_st;
		logic aw_have;
		logic w_have;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		tccs_pkg::tccs_axi_rsp_t rsp;
		logic [1:0] cnt_en;
	} tccs_top_st_t;

	tccs_top_st_t q, d;
	logic [1:0] chan_en;
	logic [1:0] ext_tick;

	// Rising edge seen on the second and third stages only
	assign ext_tick = q.ext_s2 & ~q.ext_s3;

	function automatic tccs_pkg::tccs_ctrl_t wr_ctrl(input logic [7:0] v, input logic ch);
		tccs_pkg::tccs_ctrl_t c;
		c = tccs_pkg::tccs_ctrl_t'(v);
		if (ch) begin
			c.shared_clock_mode = 1'b0;
		end
		// Codes above 1/256 are unusable with the slow crystal; clamp them
		if (c.source_select == tccs_pkg::TCCS_SRC_SLOW_XTAL && c.prescale_select > `TCCS_DIV_MAX_SLOW) begin
			c.prescale_select = `TCCS_DIV_MAX_SLOW;
		end
		return c;
	endfunction

	always_comb begin
		d = q;
		d.ext_s1 = ext_count_clock_pin_i;
		d.ext_s2 = q.ext_s1;
		d.ext_s3 = q.ext_s2;
		if (q.ctrl[0].shared_clock_mode) begin
			d.cnt_en = {2{chan_en[0]}};
		end else begin
			d.cnt_en = chan_en;
		end
		// Write channel
		if (axi_req_i.awvalid && q.rsp.awready) begin
			d.aw_have = 1'b1;
			d.awaddr = axi_req_i.awaddr;
		end
		if (axi_req_i.wvalid && q.rsp.wready) begin
			d.w_have = 1'b1;
			d.wdata = axi_req_i.wdata;
			d.wstrb = axi_req_i.wstrb;
		end
		case (q.wr_st)
			tccs_pkg::TCCS_WR_IDLE, tccs_pkg::TCCS_WR_COLLECT: begin
				d.wr_st = tccs_pkg::TCCS_WR_COLLECT;
				if (q.aw_have && q.w_have) begin
					d.rsp.bresp = `TCCS_RESP_OKAY;
					if (q.awaddr[11:2] == 10'(`TCCS_IDX_CTRL_CH0)) begin
						if (q.wstrb[0]) d.ctrl[0] = wr_ctrl(q.wdata[7:0], 1'b0);
					end else if (q.awaddr[11:2] == 10'(`TCCS_IDX_CTRL_CH1)) begin
						if (q.wstrb[0]) d.ctrl[1] = wr_ctrl(q.wdata[7:0], 1'b1);
					end else begin
						d.rsp.bresp = `TCCS_RESP_SLVERR;
					end
					d.rsp.bvalid = 1'b1;
					d.aw_have = 1'b0;
					d.w_have = 1'b0;
					d.wr_st = tccs_pkg::TCCS_WR_RESP;
				end
			end
			tccs_pkg::TCCS_WR_RESP: begin
				if (axi_req_i.bready) begin
					d.rsp.bvalid = 1'b0;
					d.wr_st = tccs_pkg::TCCS_WR_IDLE;
				end
			end
			default: begin
				d.wr_st = tccs_pkg::TCCS_WR_IDLE;
			end
		endcase
		// Each ready only while its own channel holds nothing and no response is pending
		d.rsp.awready = !d.aw_have && d.wr_st != tccs_pkg::TCCS_WR_RESP;
		d.rsp.wready = !d.w_have && d.wr_st != tccs_pkg::TCCS_WR_RESP;
		// Read channel: arready pulses with the accept, rvalid holds until rready
		d.rsp.arready = 1'b0;
		if (q.rsp.rvalid) begin
			if (axi_req_i.rready) begin
				d.rsp.rvalid = 1'b0;
			end
		end else if (axi_req_i.arvalid && !q.rsp.arready) begin
			d.rsp.arready = 1'b1;
			d.rsp.rvalid = 1'b1;
			d.rsp.rresp = `TCCS_RESP_OKAY;
			if (axi_req_i.araddr[11:2] == 10'(`TCCS_IDX_CTRL_CH0)) begin
				d.rsp.rdata = {24'h000000, q.ctrl[0]};
			end else if (axi_req_i.araddr[11:2] == 10'(`TCCS_IDX_CTRL_CH1)) begin
				d.rsp.rdata = {24'h000000, q.ctrl[1]};
			end else begin
				d.rsp.rdata = 32'h00000000;
				d.rsp.rresp = `TCCS_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.wr_st <= tccs_pkg::TCCS_WR_IDLE;
		end else begin
			q <= d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_chan
			tccs_chan u_chan (
				.clock_i(clock_i),
				.rst_n_i(rst_n_i),
				.ctrl_i(q.ctrl[g]),
				.tick_i({ext_tick[g], fast_xtal_tick_i, slow_xtal_tick_i, int_rc_tick_i}),
				.count_en_o(chan_en[g])
			);
		end
	endgenerate

	assign axi_rsp_o = q.rsp;
	assign count_en_o = q.cnt_en;
endmodule // tccs_top

// ### bench/tccs_cnt_model.sv
// Timer counter model: tallies count enables per channel.
// Assumes one-cycle enables on clock_i.
module tccs_cnt_model (
	input wire logic clock_i,
	input wire logic clr_i,
	input wire logic [1:0] count_en_i,
	output logic [15:0] cnt_o [2]
);
	timeunit 1ns;
	timeprecision 100ps;
	always_ff @(posedge clock_i) begin
		for (int c = 0; c < 2; c++) begin
			cnt_o[c] <= clr_i ? 16'h0 : cnt_o[c] + {15'h0, count_en_i[c]};
		end
	end
endmodule // tccs_cnt_model

// ### bench/tccs_top_sva.sv
// Port checker for tccs_top, shadowing control bytes from finished writes.
// Assumes the master holds aw and w until the write response.
module tccs_top_sva (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire tccs_pkg::tccs_axi_req_t axi_req_i,
	input wire tccs_pkg::tccs_axi_rsp_t axi_rsp_o,
	input wire logic int_rc_tick_i,
	input wire logic slow_xtal_tick_i,
	input wire logic fast_xtal_tick_i,
	input wire logic [1:0] ext_count_clock_pin_i,
	input wire logic [1:0] count_en_o
);
	logic [7:0] s0_q, s1_q;
	logic [11:0] ar_q;
	logic [3:0] idle_q;
	logic q;
	assign q = idle_q > 4'h6;
	always_ff @(posedge clock_i) begin
		ar_q <= axi_req_i.arvalid ? axi_req_i.araddr : ar_q;
		idle_q <= (axi_req_i.awvalid | axi_rsp_o.bvalid | !rst_n_i) ? 4'h0 : idle_q + {3'h0, idle_q != 4'hF};
		if (!rst_n_i) begin
			s0_q <= 8'h00;
			s1_q <= 8'h00;
		end else if (axi_rsp_o.bvalid & axi_req_i.bready & axi_req_i.wstrb[0]) begin
			if (axi_req_i.awaddr == 12'h1A0) s0_q <= axi_req_i.wdata[7:0];
			if (axi_req_i.awaddr == 12'h1A4) s1_q <= axi_req_i.wdata[7:0];
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	property p_rst; $rose(rst_n_i) |-> count_en_o == 2'h0; endproperty
	a_rst: assert property (p_rst) else $error("enable at reset");
	property p_cause; count_en_o != 2'h0 |-> $past(int_rc_tick_i | slow_xtal_tick_i | fast_xtal_tick_i, 2)
		|| $past(|ext_count_clock_pin_i, 3); endproperty
	a_cause: assert property (p_cause) else $error("enable without cause");
	property p_gate0; q && (!s0_q[0] || (s0_q[7:4] == 4'hF && !s0_q[2])) |-> !count_en_o[0]; endproperty
	a_gate0: assert property (p_gate0) else $error("ch0 gated");
	property p_own1; q && !s0_q[1] && !s1_q[0] |-> !count_en_o[1]; endproperty
	a_own1: assert property (p_own1) else $error("ch1 gated");
	property p_shared; q && s0_q[1] |-> count_en_o[1] == count_en_o[0]; endproperty
	a_shared: assert property (p_shared) else $error("shared");
	property p_rsv; axi_rsp_o.rvalid && ar_q == 12'h1A4 |-> axi_rsp_o.rdata[1] == 1'b0; endproperty
	a_rsv: assert property (p_rsv) else $error("ch1 bit1");
	property p_src; axi_rsp_o.rvalid && ar_q == 12'h1A0 |-> axi_rsp_o.rdata[3:0] == s0_q[3:0]; endproperty
	a_src: assert property (p_src) else $error("ch0 readback");
	property p_slow; axi_rsp_o.rvalid && ar_q == 12'h1A0 && axi_rsp_o.rdata[3:2] == 2'h1
		|-> axi_rsp_o.rdata[7:4] <= 4'h8; endproperty
	a_slow: assert property (p_slow) else $error("slow code");
	c_shared: cover property (s0_q[1] && count_en_o[1]);
	c_ext: cover property (s1_q[3:2] == 2'h3 && count_en_o[1]);
	c_err: cover property (axi_rsp_o.rvalid && axi_rsp_o.rresp == 2'h2);
endmodule // tccs_top_sva
bind tccs_top tccs_top_sva chk_u (.clock_i, .rst_n_i, .axi_req_i, .axi_rsp_o, .int_rc_tick_i, .slow_xtal_tick_i,
	.fast_xtal_tick_i, .ext_count_clock_pin_i, .count_en_o);

// ### bench/test_timer_count_clock_select.sv
// Bench for tccs_top: AXI4-Lite register calls, then counted enables.
// Assumes the counter model and the bound checker.
`include "tccs_map.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; $display("CHECK FAILED %0t %h", $time, a); end end
module test_timer_count_clock_select;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [11:0] A0 = `TCCS_OFS_CTRL_CH0;
	localparam logic [11:0] A1 = `TCCS_OFS_CTRL_CH1;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic clr = 1'b1;
	logic [4:0] src = 5'h00;
	logic [1:0] en;
	logic [15:0] cnt [2];
	logic [3:0] dv [4] = '{4'h0, 4'h1, 4'h4, 4'hF};
	tccs_pkg::tccs_axi_req_t req = '0;
	tccs_pkg::tccs_axi_rsp_t rsp;
	int n_errors = 0;
	int tests_run = 0;
	always #12.5 clock_i = ~clock_i;
	tccs_top dut_u (.clock_i, .rst_n_i, .axi_req_i(req), .axi_rsp_o(rsp), .int_rc_tick_i(src[0]),
		.slow_xtal_tick_i(src[1]), .fast_xtal_tick_i(src[2]), .ext_count_clock_pin_i(src[4:3]), .count_en_o(en));
	tccs_cnt_model cnt_u (.clock_i, .clr_i(clr), .count_en_i(en), .cnt_o(cnt));
	task automatic report_and_stop();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic step(inout int k);
		@(posedge clock_i);
		k++;
		if (k > 64) begin
			n_errors++;
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		int k = 0;
		req.awaddr <= a;
		req.wdata <= {24'h0, d};
		req.wstrb <= 4'hF;
		{req.awvalid, req.wvalid, req.bready} <= 3'h7;
		do begin
			step(k);
			if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
			if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		req.bready <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
		int k = 0;
		req.araddr <= a;
		{req.arvalid, req.rready} <= 2'h3;
		do step(k); while (rsp.rvalid !== 1'b1);
		{req.arvalid, req.rready} <= 2'h0;
		`CHK(rsp.rdata, {24'h0, e})
		`CHK(rsp.rresp, r)
		@(posedge clock_i);
	endtask
	task automatic pulse(input int s, input int n, input int w);
		repeat (n) begin
			src[s] <= 1'b1;
			repeat (w) @(posedge clock_i);
			src[s] <= 1'b0;
			repeat (w) @(posedge clock_i);
		end
	endtask
	task automatic chk(input logic [15:0] c0, input logic [15:0] c1);
		repeat (8) @(posedge clock_i);
		`CHK(cnt[0], c0)
		`CHK(cnt[1], c1)
		clr <= 1'b1;
		@(posedge clock_i);
		clr <= 1'b0;
	endtask
	initial begin
		repeat (2) @(posedge clock_i);
		{rst_n_i, clr} <= 2'h2;
		@(posedge clock_i);
		rd(A0, 8'h00, 2'h0);
		rd(A1, 8'h00, 2'h0);
		rd(12'h070, 8'h00, 2'h2);
		pulse(0, 4, 1);
		chk(0, 0);
		for (int s = 0; s < 3; s++) begin
			foreach (dv[i]) begin
				wr(A0, 8'h00);
				wr(A0, {dv[i], 2'(s), 2'h1});
				pulse(s, 16, 1);
				pulse((s + 1) % 3, 16, 1);
				chk(16'h10 >> dv[i], 0);
			end
		end
		wr(A0, 8'hE1);
		pulse(0, 16384, 1);
		chk(1, 0);
		wr(A0, 8'h00);
		wr(A0, 8'hA5);
		rd(A0, 8'h85, 2'h0);
		pulse(1, 256, 1);
		chk(1, 0);
		wr(A1, 8'h3F);
		rd(A1, 8'h3D, 2'h0);
		pulse(4, 3, 8);
		chk(0, 3);
		wr(A1, 8'h00);
		wr(A0, 8'h00);
		wr(A0, 8'h03);
		pulse(0, 4, 1);
		chk(4, 4);
		wr(A1, 8'h11);
		wr(A0, 8'h01);
		pulse(0, 4, 1);
		chk(4, 2);
		wr(A0, 8'h00);
		wr(A1, 8'h00);
		pulse(0, 4, 1);
		chk(0, 0);
		report_and_stop();
	end
endmodule // test_timer_count_clock_select
